/* File: shared/clock_mode_pkg.sv */
package clock_mode_pkg;
    // Register byte offsets.
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  OFS_CLK_MODE  = 8'h00;
    localparam logic [7:0]  OFS_MODE2     = 8'h04;
    localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;
    localparam logic [7:0]  OFS_STATE     = 8'h10;

    // Clock-mode register layout.
    localparam int          SEL_BIT       = 0;
    localparam int          IDLE_EN_BIT   = 1;
    localparam int          HS_RDY_BIT    = 2;
    localparam int          LS_RDY_BIT    = 3;
    localparam int          DIV_LSB       = 5;
    localparam int          DIV_MSB       = 7;
    localparam logic [7:0]  CLK_MODE_RST  = 8'h03;
    localparam logic [7:0]  CLK_MODE_WMSK = 8'hE3;

    // Second mode register layout.
    localparam int          KEEP_BIT      = 7;
    localparam logic        KEEP_RST      = 1'b0;

    // Selection code is {source select, divider select}.
    localparam int          SEL_W         = 4;
    localparam int          SEL_HL        = 3;
    localparam logic [2:0]  DIV_FIRST_HS  = 3'h2;
    localparam logic [5:0]  DIV_FULL_MASK = 6'h3F;
    localparam int          DIV_CNT_W     = 6;

    // Switch delay in current clock periods, and slow ready delay in slow periods.
    localparam logic [2:0]  SWITCH_BASE   = 3'h4;
    localparam logic [1:0]  LS_READY_CNT  = 2'h2;

    // Interrupt status bits.
    localparam int          IRQ_W         = 4;
    localparam int          IRQ_WAKE      = 0;
    localparam int          IRQ_HALT      = 1;
    localparam int          IRQ_SWITCH    = 2;
    localparam int          IRQ_HS_READY  = 3;

    // AHB-Lite encodings.
    localparam logic        HRESP_OKAY    = 1'b0;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_IDLE0,
        ST_IDLE1,
        ST_SLEEP0,
        ST_SLEEP1
    } power_state_e;
endpackage : clock_mode_pkg

/* File: shared/clk_switch_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface clk_switch_if;
    logic start;
    logic cur_tick;
    logic tar_tick;
    logic busy;
    logic done;
    modport ctl   (output start, cur_tick, tar_tick, input busy, done);
    modport timer (input start, cur_tick, tar_tick, output busy, done);
endinterface : clk_switch_if
`default_nettype wire

/* File: verilog/clock_switch_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module clock_switch_timer
    import clock_mode_pkg::*;
(
    // Clock and reset.
    input  wire logic   hclk,
    input  wire logic   hresetn,
    // Switch control.
    clk_switch_if.timer sw
);
    logic [2:0] cnt_reg;
    logic       busy_reg;
    logic       done_reg;

    // [RULE15] Switch delay count.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg  <= 3'h0;
            busy_reg <= 1'b0;
        end else if (sw.start) begin
            cnt_reg  <= 3'h0;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            if (cnt_reg != SWITCH_BASE) begin
                if (sw.cur_tick) begin
                    cnt_reg <= cnt_reg + 3'h1;
                end
            end else if (sw.tar_tick) begin
                busy_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= busy_reg && !sw.start && cnt_reg == SWITCH_BASE && sw.tar_tick;
        end
    end

    assign sw.busy = busy_reg;
    assign sw.done = done_reg;

    // [RULE15] Full base count.
    a_switch_base_count: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
        $rose(done_reg) |-> $past(cnt_reg) == SWITCH_BASE && !busy_reg)
        else $error("switch finished before base count");
endmodule : clock_switch_timer
`default_nettype wire

/* File: verilog/system_clock_power_mode_control.sv */
// Contract
// [RULE1] Source select one picks undivided fast clock.
// [RULE2] Divider codes: slow, or fast over 64..2.
// [RULE3] Normal mode: fast divided, slow and time-base on.
// [RULE4] Slow mode: slow clock, fast clock off.
// [RULE5] Switching to slow stops fast oscillator.
// [RULE6] Time-base clock comes from slow oscillator.
// [RULE7] Stop with idle disabled enters sleep.
// [RULE8] Sleep without watchdog stops everything.
// [RULE9] Sleep with watchdog keeps slow oscillator.
// [RULE10] Idle without keep: slow and time-base only.
// [RULE11] Idle with keep: system clock keeps running.
// [RULE12] Idle with keep: selected oscillator stays on.
// [RULE13] Slow ready low in deep sleep, 1-2 ticks.
// [RULE14] Fast ready clears at reset, sets when stable.
// [RULE15] Switch takes four current periods plus variable.
// [RULE16] Bit four of clock mode reads zero.
// [RULE17] Idle clock keep at bit seven.
// [RULE18] Software checks fast ready before fast use.
// [RULE19] Wake resumes with held clock selection.
`timescale 1ns/100ps
`default_nettype none
module system_clock_power_mode_control
    import clock_mode_pkg::*;
(
    // Clock and reset.
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave.
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Oscillator pins.
    input  wire logic              fast_osc_clk,
    input  wire logic              fast_osc_stable,
    input  wire logic              slow_osc_clk,
    output logic                   fast_osc_enable,
    output logic                   slow_osc_enable,
    // CPU and watchdog.
    input  wire logic              halt_req,
    input  wire logic              wake_req,
    input  wire logic              watchdog_enable,
    // Clock enables and ticks.
    output logic                   cpu_clock_enable,
    output logic                   sys_clock_enable,
    output logic                   time_base_enable,
    output logic                   sys_tick,
    output logic                   cpu_tick,
    output logic                   time_base_tick,
    output logic [SEL_W-1:0]       sys_select,
    // Interrupt.
    output logic                   irq
);
    function automatic logic uses_fast(input logic [SEL_W-1:0] sel);
        return sel[SEL_HL] || sel[2:0] >= DIV_FIRST_HS;
    endfunction : uses_fast

    function automatic logic sel_tick(input logic [SEL_W-1:0] sel,
                                      input logic fe, input logic se,
                                      input logic [DIV_CNT_W-1:0] cnt);
        logic [DIV_CNT_W-1:0] mask;
        mask = DIV_FULL_MASK >> (sel[2:0] - DIV_FIRST_HS);
        if (sel[SEL_HL]) begin
            return fe;
        end else if (sel[2:0] < DIV_FIRST_HS) begin
            return se;
        end else begin
            return fe && ((cnt & mask) == mask);
        end
    endfunction : sel_tick

    logic [2:0]           fast_sync_reg;
    logic [2:0]           slow_sync_reg;
    logic [1:0]           stable_sync_reg;
    logic                 fast_edge;
    logic                 slow_edge;
    logic [DIV_CNT_W-1:0] div_cnt_reg;
    logic [7:0]           clk_mode_reg;
    logic                 keep_reg;
    logic [SEL_W-1:0]     pend_sel;
    logic [SEL_W-1:0]     active_sel_reg;
    power_state_e         state_reg;
    power_state_e         state_next;
    logic                 hs_ready_reg;
    logic                 ls_ready_reg;
    logic [1:0]           ls_cnt_reg;
    logic [IRQ_W-1:0]     irq_stat_reg;
    logic [IRQ_W-1:0]     irq_mask_reg;
    logic [IRQ_W-1:0]     irq_set;
    logic                 wr_pend_reg;
    logic [ADDR_W-1:0]    wr_addr_reg;
    logic                 addr_ok;
    logic                 mode_wr;
    logic [31:0]          rd_mux;
    logic                 run_next;
    logic                 sysen_next;
    clk_switch_if         sw ();

    // Pin synchronisers; the third stage only feeds edge detection.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_sync_reg   <= 3'h0;
            slow_sync_reg   <= 3'h0;
            stable_sync_reg <= 2'h0;
        end else begin
            fast_sync_reg   <= {fast_sync_reg[1:0], fast_osc_clk};
            slow_sync_reg   <= {slow_sync_reg[1:0], slow_osc_clk};
            stable_sync_reg <= {stable_sync_reg[0], fast_osc_stable};
        end
    end
    assign fast_edge = fast_sync_reg[1] && !fast_sync_reg[2];
    assign slow_edge = slow_sync_reg[1] && !slow_sync_reg[2];

    // [RULE2] Fast clock divider.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_reg <= '0;
        end else if (fast_edge) begin
            div_cnt_reg <= div_cnt_reg + 6'h01;
        end
    end

    // AHB-Lite address phase capture.
    assign addr_ok = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[ADDR_W-1:0];
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    assign mode_wr  = wr_pend_reg && wr_addr_reg == OFS_CLK_MODE;
    assign pend_sel = {clk_mode_reg[SEL_BIT], clk_mode_reg[DIV_MSB:DIV_LSB]};

    // [RULE16] Only writable bits are stored.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_mode_reg <= CLK_MODE_RST & CLK_MODE_WMSK;
        end else if (mode_wr) begin
            clk_mode_reg <= hwdata[7:0] & CLK_MODE_WMSK;
        end
    end

    // [RULE17] Idle clock keep bit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            keep_reg <= KEEP_RST;
        end else if (wr_pend_reg && wr_addr_reg == OFS_MODE2) begin
            keep_reg <= hwdata[KEEP_BIT];
        end
    end

    // [RULE15] Start switch delay on a selection change.
    assign sw.start    = mode_wr &&
        {hwdata[SEL_BIT], hwdata[DIV_MSB:DIV_LSB]} != pend_sel;
    assign sw.cur_tick = sel_tick(active_sel_reg, fast_edge, slow_edge, div_cnt_reg);
    assign sw.tar_tick = sel_tick(pend_sel, fast_edge, slow_edge, div_cnt_reg);

    clock_switch_timer u_switch (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sw      (sw.timer)
    );

    // [RULE19] Active selection only changes by a completed switch.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_sel_reg <= {CLK_MODE_RST[SEL_BIT], CLK_MODE_RST[DIV_MSB:DIV_LSB]};
        end else if (sw.done) begin
            active_sel_reg <= pend_sel;
        end
    end

    // [RULE7] Stop instruction mode choice.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (halt_req) begin
                    if (clk_mode_reg[IDLE_EN_BIT]) begin
                        state_next = keep_reg ? ST_IDLE1 : ST_IDLE0;
                    end else begin
                        state_next = watchdog_enable ? ST_SLEEP1 : ST_SLEEP0;
                    end
                end
            end
            ST_IDLE0, ST_IDLE1, ST_SLEEP0, ST_SLEEP1: begin
                if (wake_req) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    assign run_next   = state_next == ST_RUN;
    assign sysen_next = run_next || state_next == ST_IDLE1;

    // [RULE3] [RULE8] [RULE11] Enables per mode.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_clock_enable <= 1'b1;
            sys_clock_enable <= 1'b1;
            slow_osc_enable  <= 1'b1;
            time_base_enable <= 1'b1;
            fast_osc_enable  <= 1'b1;
        end else begin
            cpu_clock_enable <= run_next;
            sys_clock_enable <= sysen_next;
            // [RULE9] Watchdog keeps slow oscillator.
            slow_osc_enable  <= state_next != ST_SLEEP0;
            // [RULE10] Time base runs in both idles.
            time_base_enable <= sysen_next || state_next == ST_IDLE0;
            // [RULE4] [RULE5] [RULE12] Fast oscillator by selection.
            fast_osc_enable  <= sysen_next &&
                (uses_fast(sw.done ? pend_sel : active_sel_reg) ||
                 uses_fast(mode_wr ? {hwdata[SEL_BIT], hwdata[DIV_MSB:DIV_LSB]} : pend_sel));
        end
    end

    // [RULE1] [RULE6] Gated clock ticks.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_tick       <= 1'b0;
            cpu_tick       <= 1'b0;
            time_base_tick <= 1'b0;
            sys_select     <= {CLK_MODE_RST[SEL_BIT], CLK_MODE_RST[DIV_MSB:DIV_LSB]};
        end else begin
            sys_tick       <= sys_clock_enable && sw.cur_tick;
            cpu_tick       <= cpu_clock_enable && sw.cur_tick;
            time_base_tick <= time_base_enable && slow_edge;
            sys_select     <= active_sel_reg;
        end
    end

    // [RULE14] Fast ready flag.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hs_ready_reg <= 1'b0;
        end else begin
            hs_ready_reg <= fast_osc_enable && stable_sync_reg[1];
        end
    end

    // [RULE13] Slow ready after two slow edges.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ls_cnt_reg   <= 2'h0;
            ls_ready_reg <= 1'b0;
        end else if (!slow_osc_enable) begin
            ls_cnt_reg   <= 2'h0;
            ls_ready_reg <= 1'b0;
        end else begin
            if (slow_edge && ls_cnt_reg != LS_READY_CNT) begin
                ls_cnt_reg <= ls_cnt_reg + 2'h1;
            end
            ls_ready_reg <= ls_cnt_reg == LS_READY_CNT;
        end
    end

    // Interrupt events; a set in the clear cycle wins.
    always_comb begin
        irq_set               = '0;
        irq_set[IRQ_WAKE]     = state_reg != ST_RUN && run_next;
        irq_set[IRQ_HALT]     = state_reg == ST_RUN && !run_next;
        irq_set[IRQ_SWITCH]   = sw.done;
        irq_set[IRQ_HS_READY] = fast_osc_enable && stable_sync_reg[1] && !hs_ready_reg;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_reg <= '0;
        end else if (wr_pend_reg && wr_addr_reg == OFS_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~hwdata[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= '0;
        end else if (wr_pend_reg && wr_addr_reg == OFS_IRQ_MASK) begin
            irq_mask_reg <= hwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // [RULE16] Read mux; unmapped reads are zero.
    always_comb begin
        rd_mux = '0;
        case (haddr[ADDR_W-1:0])
            OFS_CLK_MODE: begin
                rd_mux[7:0]         = clk_mode_reg;
                rd_mux[HS_RDY_BIT]  = hs_ready_reg;
                rd_mux[LS_RDY_BIT]  = ls_ready_reg;
            end
            OFS_MODE2: begin
                rd_mux[KEEP_BIT]    = keep_reg;
            end
            OFS_IRQ_STAT: begin
                rd_mux[IRQ_W-1:0]   = irq_stat_reg;
            end
            OFS_IRQ_MASK: begin
                rd_mux[IRQ_W-1:0]   = irq_mask_reg;
            end
            OFS_STATE: begin
                rd_mux[2:0]         = state_reg;
                rd_mux[3]           = sw.busy;
                rd_mux[7:4]         = active_sel_reg;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // [RULE1] Undivided fast selection.
    a_fast_sel_tick: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE1]
        sys_clock_enable && active_sel_reg[SEL_HL] && fast_edge |=> sys_tick)
        else $error("fast selection missed a system tick");

    // [RULE2] Slow divider codes.
    a_slow_code_tick: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE2]
        sys_clock_enable && !uses_fast(active_sel_reg) && !slow_edge |=> !sys_tick)
        else $error("slow selection ticked without slow edge");

    // [RULE3] Normal mode clocks.
    a_normal_clocks: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE3]
        state_reg == ST_RUN && uses_fast(active_sel_reg)
        |-> fast_osc_enable && slow_osc_enable && time_base_enable)
        else $error("normal mode clock missing");

    // [RULE4] Slow mode keeps fast oscillator off.
    a_slow_fast_off: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE4]
        state_reg == ST_RUN && !uses_fast(active_sel_reg) && !uses_fast(pend_sel)
        |-> !fast_osc_enable)
        else $error("fast oscillator on in slow mode");

    // [RULE7] Sleep entry.
    a_sleep_entry: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE7]
        state_reg == ST_RUN && halt_req && !clk_mode_reg[IDLE_EN_BIT]
        |=> state_reg == ST_SLEEP0 || state_reg == ST_SLEEP1)
        else $error("stop without idle did not sleep");

    // [RULE8] Deep sleep stops all.
    a_sleep0_off: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
        state_reg == ST_SLEEP0 |-> !cpu_clock_enable && !sys_clock_enable
        && !slow_osc_enable && !time_base_enable && !fast_osc_enable)
        else $error("clock running in deep sleep");

    // [RULE9] Watchdog sleep.
    a_sleep1_wdt: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
        state_reg == ST_SLEEP1 |-> slow_osc_enable && !sys_clock_enable && !time_base_enable)
        else $error("watchdog sleep clocks wrong");

    // [RULE10] Idle without keep.
    a_idle0_clocks: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
        state_reg == ST_IDLE0 |-> !sys_clock_enable && slow_osc_enable && time_base_enable)
        else $error("idle without keep clocks wrong");

    // [RULE11] Idle with keep.
    a_idle1_clocks: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
        state_reg == ST_IDLE1 |-> sys_clock_enable && !cpu_clock_enable && slow_osc_enable)
        else $error("idle with keep clocks wrong");

    // [RULE12] Selected oscillator stays on.
    a_idle1_osc: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
        state_reg == ST_IDLE1 && uses_fast(active_sel_reg) |-> fast_osc_enable)
        else $error("selected oscillator off in idle");

    // [RULE13] Slow ready low in deep sleep.
    a_ls_ready_low: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE13]
        state_reg == ST_SLEEP0 [*2] |-> !ls_ready_reg)
        else $error("slow ready high in deep sleep");

    // [RULE14] Fast ready needs running oscillator.
    a_hs_ready_src: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE14]
        $rose(hs_ready_reg) |-> $past(fast_osc_enable) && $past(stable_sync_reg[1]))
        else $error("fast ready rose without stable oscillator");

    // [RULE19] Selection held over wake.
    a_wake_select: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE19]
        state_reg != ST_RUN && !sw.done |=> active_sel_reg == $past(active_sel_reg))
        else $error("selection changed while stopped");

    a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_set[IRQ_HALT] |=> irq_stat_reg[IRQ_HALT])
        else $error("halt event lost");
endmodule : system_clock_power_mode_control
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
    import clock_mode_pkg::*;
;
    logic             hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, rd_pend = 1'b0, fstab = 1'b0;
    logic             halt_req = 1'b0, wake_req = 1'b0, wdg = 1'b0, fclk = 1'b0, sclk = 1'b0;
    logic [31:0]      haddr = 32'h0, hwdata = 32'h0;
    logic [1:0]       htrans = 2'h0;
    wire logic        hreadyout, hresp, fen, sen, cpu_en, sys_en, tb_en, st, ct, tt, irq;
    wire logic [31:0] hrdata;
    wire logic [SEL_W-1:0] sys_select;
    int               bad_count = 0, compares = 0, cyc = 0, seed = 32'hA907;
    logic [31:0]      q[$];
    logic [3:0]       en_tab[4] = '{4'h7, 4'h3, 4'h1, 4'h0};
    logic [2:0]       st_tab[4] = '{3'h2, 3'h1, 3'h4, 3'h3};

    system_clock_power_mode_control uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fast_osc_clk(fclk),
        .fast_osc_stable(fstab), .slow_osc_clk(sclk), .fast_osc_enable(fen),
        .slow_osc_enable(sen), .halt_req(halt_req), .wake_req(wake_req),
        .watchdog_enable(wdg), .cpu_clock_enable(cpu_en), .sys_clock_enable(sys_en),
        .time_base_enable(tb_en), .sys_tick(st), .cpu_tick(ct), .time_base_tick(tt),
        .sys_select(sys_select), .irq(irq));

    initial forever #2.5 hclk = ~hclk;

    // Oscillator pins: fast period 4 cycles, slow period 20 cycles.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1 && fen === 1'b1) fclk <= ~fclk;
        if (cyc % 10 == 9) sclk <= ~sclk;
    end

    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task test_done;
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done

    // Read data is compared against the oldest expectation at the end of its data phase.
    always @(posedge hclk) if (rd_pend && hreadyout === 1'b1) check("hrdata", hrdata, q.pop_front());

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d; rd_pend <= !w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_pend <= 1'b0;
        #1;
    endtask : bus

    task rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task pulse(input logic h);
        @(posedge hclk);
        if (h) halt_req <= 1'b1; else wake_req <= 1'b1;
        @(posedge hclk);
        halt_req <= 1'b0; wake_req <= 1'b0;
        #1;
    endtask : pulse

    // Cycles between two ticks of the system clock, or of the time-base clock.
    task gap(input logic tb, output int g);
        int t;
        @(posedge hclk);
        for (t = 0; t < 600 && (tb ? tt : st) !== 1'b1; t++) @(posedge hclk);
        @(posedge hclk);
        for (g = 1; g < 600 && (tb ? tt : st) !== 1'b1; g++) @(posedge hclk);
    endtask : gap

    initial begin
        #300000;
        bad_count++;
        test_done;
    end

    initial begin
        int i, k, t, g;
        logic [2:0] c;
        logic s, f, idl, kp;
        logic [31:0] d;
        logic [3:0] e;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(OFS_CLK_MODE, 32'h03);
        @(posedge hclk);
        fstab <= 1'b1;
        repeat (200) @(posedge hclk);
        rd(OFS_CLK_MODE, 32'h0F);
        rd(OFS_MODE2, 32'h0);
        rd(OFS_STATE, 32'h80);
        wr_unmapped: begin
            bus(1'b1, 8'h20, $random(seed));
            rd(8'h20, 32'h0);
        end
        $display("test reset done");
        for (i = 0; i < 9; i++) begin
            c = i[2:0]; s = (i == 8); e = {s, c}; f = !(!s && c < 3'h2);
            bus(1'b1, OFS_CLK_MODE, {24'h0, c, 3'b111, 1'b1, s});
            for (t = 0; t < 3000 && sys_select !== e; t++) @(posedge hclk);
            repeat (10) @(posedge hclk);
            check("sys_select", sys_select, e);
            check("fast_osc_enable", fen, f);
            gap(1'b0, g);
            check("sys_tick gap", g, s ? 4 : (c < 3'h2) ? 20 : 4 << (8 - c));
            rd(OFS_CLK_MODE, {24'h0, c, 2'b01, f, 1'b1, s});
            rd(OFS_STATE, {24'h0, e, 4'h0});
        end
        gap(1'b1, g);
        check("time_base gap", g, 20);
        $display("test clock select done");
        for (k = 0; k < 4; k++) begin
            idl = (k < 2); kp = (k == 0);
            @(posedge hclk);
            wdg <= (k == 2);
            d = $random(seed); d[7] = kp;
            bus(1'b1, OFS_MODE2, d);
            rd(OFS_MODE2, {24'h0, kp, 7'h0});
            bus(1'b1, OFS_CLK_MODE, {30'h0, idl, 1'b1});
            pulse(1'b1);
            check("enables", {cpu_en, sys_en, tb_en, sen}, en_tab[k]);
            check("fast_osc_enable", fen, k == 0);
            rd(OFS_STATE, {24'h0, 4'h8, 1'b0, st_tab[k]});
            check("cpu_tick", ct, 1'b0);
            if (k == 3) rd(OFS_CLK_MODE, 32'h01);
            pulse(1'b0);
            check("cpu_clock_enable", cpu_en, 1'b1);
            check("sys_select", sys_select, 4'h8);
            repeat (50) @(posedge hclk);
            rd(OFS_CLK_MODE, {28'h0, 2'b11, idl, 1'b1});
        end
        $display("test power modes done");
        rd(OFS_IRQ_STAT, 32'hF);
        check("irq masked", irq, 1'b0);
        bus(1'b1, OFS_IRQ_MASK, 32'h4);
        rd(OFS_IRQ_MASK, 32'h4);
        check("irq raised", irq, 1'b1);
        bus(1'b1, OFS_IRQ_STAT, 32'hB);
        rd(OFS_IRQ_STAT, 32'h4);
        check("irq held", irq, 1'b1);
        bus(1'b1, OFS_IRQ_STAT, 32'h4);
        rd(OFS_IRQ_STAT, 32'h0);
        check("irq cleared", irq, 1'b0);
        check("hresp", hresp, HRESP_OKAY);
        check("pending reads", q.size(), 0);
        $display("test interrupt done");
        test_done;
    end
endmodule : testbench
`default_nettype wire
